// ---- rtl/call_move_return_exec.sv ----
// Executor for call, moves, immediate load, no-op and interrupt return.
// Assumes decoded instructions arrive with a valid/ready handshake on clk,
// and that the interrupt controller pulses gieClear when it takes an interrupt.
`timescale 1ns/100ps

module call_move_return_exec #(
    parameter int STACK_DEPTH = exec_pkg::STACK_DEPTH,
    parameter int REG_COUNT = exec_pkg::REG_COUNT
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic instrValid,
    output logic instrReady,
    input exec_pkg::instr_t instr,
    input wire logic gieClear,
    input wire logic [exec_pkg::REG_ADDR_W-1:0] peekAddr,
    output logic [exec_pkg::ACC_W-1:0] peekData,
    output logic [exec_pkg::PC_W-1:0] pc,
    output logic [exec_pkg::ACC_W-1:0] accumulator,
    output logic zeroFlag,
    output logic global_interrupt_enable,
    output logic [$clog2(STACK_DEPTH):0] stackPointer
);

    localparam int IDX_W = $clog2(STACK_DEPTH);

    // Execute takes the instruction; the second cycle of long ones only waits
    typedef enum logic {EXEC, SECOND} state_t;

    state_t state_reg;                                   // Sequencer state
    logic [exec_pkg::PC_W-1:0] pc_reg;                   // Program counter
    logic [exec_pkg::ACC_W-1:0] acc_reg;                 // Accumulator
    logic zero_reg;                                      // Zero flag
    logic gie_reg;                                       // Global interrupt enable
    logic [IDX_W:0] sp_reg;                              // Stack entries in use
    logic [exec_pkg::ACC_W-1:0] peek_reg;                // Registered memory view
    logic [exec_pkg::PC_W-1:0] stackMem [STACK_DEPTH];   // Return stack
    logic [exec_pkg::ACC_W-1:0] dataMem [REG_COUNT];     // Data registers

    logic take;                                          // Instruction accepted
    logic [exec_pkg::PC_W-1:0] pcPlusOne;                // Return address
    logic [exec_pkg::PC_W-1:0] topOfStack;               // Entry a return pops
    logic [exec_pkg::ACC_W-1:0] memVal;                  // Addressed register
    logic [IDX_W-1:0] pushIdx;                           // Slot a call fills
    logic [IDX_W-1:0] popIdx;                            // Slot a return reads

    // Index is the low bits of the count, so overflow wraps instead of trapping
    function automatic logic [IDX_W-1:0] slot(input logic [IDX_W:0] count);
        return count[IDX_W-1:0];
    endfunction

    assign instrReady = (state_reg == EXEC);
    assign take = instrValid && instrReady;
    assign pcPlusOne = pc_reg + exec_pkg::PC_STEP;
    assign pushIdx = slot(sp_reg);
    assign popIdx = slot(sp_reg - 1'b1);
    assign topOfStack = stackMem[popIdx];
    assign memVal = dataMem[instr.regAddr];

    assign pc = pc_reg;
    assign accumulator = acc_reg;
    assign zeroFlag = zero_reg;
    assign global_interrupt_enable = gie_reg;
    assign stackPointer = sp_reg;
    assign peekData = peek_reg;

    // Sequencer: two-cycle instructions hold off the next one for a cycle
    always_ff @(posedge clk) begin
        if (reset) begin
            state_reg <= EXEC;
        end else if (take && (instr.op == exec_pkg::OP_LONG_SUBROUTINE_CALL
                || instr.op == exec_pkg::OP_RETURN_ENABLE_INTERRUPTS)) begin
            state_reg <= SECOND;
        end else begin
            state_reg <= EXEC;
        end
    end

    // Program counter: target, popped address or sequential advance
    always_ff @(posedge clk) begin
        if (reset) begin
            pc_reg <= exec_pkg::PC_RESET;
        end else if (take) begin
            unique case (instr.op)
                exec_pkg::OP_LONG_SUBROUTINE_CALL: begin
                    pc_reg <= instr.target;
                end
                exec_pkg::OP_RETURN_ENABLE_INTERRUPTS: begin
                    pc_reg <= topOfStack;
                end
                default: begin
                    // No-op and the data moves just step on
                    pc_reg <= pcPlusOne;
                end
            endcase
        end
    end

    // Return stack contents: only a call writes
    always_ff @(posedge clk) begin
        if (take && instr.op == exec_pkg::OP_LONG_SUBROUTINE_CALL) begin
            stackMem[pushIdx] <= pcPlusOne;
        end
    end

    // Stack pointer follows pushes and pops
    always_ff @(posedge clk) begin
        if (reset) begin
            sp_reg <= '0;
        end else if (take && instr.op == exec_pkg::OP_LONG_SUBROUTINE_CALL) begin
            sp_reg <= sp_reg + 1'b1;
        end else if (take && instr.op == exec_pkg::OP_RETURN_ENABLE_INTERRUPTS) begin
            sp_reg <= sp_reg - 1'b1;
        end
    end

    // Accumulator: immediate load or move with accumulator destination
    always_ff @(posedge clk) begin
        if (reset) begin
            acc_reg <= exec_pkg::ACC_RESET;
        end else if (take && instr.op == exec_pkg::OP_LOAD_IMMEDIATE_ACC) begin
            acc_reg <= instr.imm;
        end else if (take && instr.op == exec_pkg::OP_MOVE_REG_SELECT_DEST
                && instr.destSel == exec_pkg::DEST_ACC) begin
            acc_reg <= memVal;
        end
    end

    // Data registers: store from accumulator or write the value back unchanged
    always_ff @(posedge clk) begin
        if (take && instr.op == exec_pkg::OP_MOVE_ACC_TO_REG) begin
            dataMem[instr.regAddr] <= acc_reg;
        end else if (take && instr.op == exec_pkg::OP_MOVE_REG_SELECT_DEST
                && instr.destSel == exec_pkg::DEST_REG) begin
            // Write-back is harmless and lets software test a register for zero
            dataMem[instr.regAddr] <= memVal;
        end
    end

    // Zero flag: only the register move touches it
    always_ff @(posedge clk) begin
        if (reset) begin
            zero_reg <= 1'b0;
        end else if (take && instr.op == exec_pkg::OP_MOVE_REG_SELECT_DEST) begin
            zero_reg <= (memVal == exec_pkg::ZERO_WORD);
        end
    end

    // Global interrupt enable: the return's set wins over a same-cycle clear
    always_ff @(posedge clk) begin
        if (reset) begin
            gie_reg <= exec_pkg::GIE_RESET;
        end else if (take && instr.op == exec_pkg::OP_RETURN_ENABLE_INTERRUPTS) begin
            gie_reg <= 1'b1;
        end else if (gieClear) begin
            gie_reg <= 1'b0;
        end
    end

    // Registered view of one data register for inspection
    always_ff @(posedge clk) begin
        if (reset) begin
            peek_reg <= exec_pkg::ACC_RESET;
        end else begin
            peek_reg <= dataMem[peekAddr];
        end
    end

    // Checks on the executed effects
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    logic takeCall;
    logic takeStore;
    logic takeLoad;
    logic takeMove;
    logic takeRet;
    logic takeNop;
    assign takeCall = take && instr.op == exec_pkg::OP_LONG_SUBROUTINE_CALL;
    assign takeStore = take && instr.op == exec_pkg::OP_MOVE_ACC_TO_REG;
    assign takeLoad = take && instr.op == exec_pkg::OP_LOAD_IMMEDIATE_ACC;
    assign takeMove = take && instr.op == exec_pkg::OP_MOVE_REG_SELECT_DEST;
    assign takeRet = take && instr.op == exec_pkg::OP_RETURN_ENABLE_INTERRUPTS;
    assign takeNop = take && instr.op == exec_pkg::OP_NOP;

    logic [exec_pkg::PC_W-1:0] stackTopNow;
    logic [exec_pkg::ACC_W-1:0] storedVal;
    logic [exec_pkg::REG_ADDR_W-1:0] lastAddr;
    assign stackTopNow = stackMem[popIdx];
    assign storedVal = dataMem[lastAddr];
    always_ff @(posedge clk) begin
        lastAddr <= instr.regAddr;
    end

    a_call_push: assert property (takeCall |=> stackTopNow == $past(pcPlusOne))
        else $error("call did not push the return address");
    a_call_target: assert property (takeCall |=> pc == $past(instr.target)
        && zeroFlag == $past(zeroFlag))
        else $error("call target or flag wrong");
    a_two_cycle: assert property ((takeCall || takeRet) |=> !instrReady ##1 instrReady)
        else $error("long instruction not two cycles");
    a_store_acc: assert property (takeStore |=> storedVal == $past(accumulator)
        && $stable(accumulator) && $stable(zeroFlag) && instrReady)
        else $error("store of accumulator wrong");
    a_imm_load: assert property (takeLoad |=> accumulator == $past(instr.imm)
        && $stable(zeroFlag))
        else $error("immediate load wrong");
    a_move_acc: assert property (takeMove && instr.destSel == exec_pkg::DEST_ACC
        |=> accumulator == $past(memVal))
        else $error("move to accumulator wrong");
    a_move_back: assert property (takeMove && instr.destSel == exec_pkg::DEST_REG
        |=> storedVal == $past(memVal) && $stable(accumulator))
        else $error("move back changed data");
    a_move_zero: assert property (takeMove |=> zeroFlag == ($past(memVal) == exec_pkg::ZERO_WORD))
        else $error("zero flag wrong after move");
    a_ret_pop: assert property (takeRet |=> pc == $past(topOfStack)
        && stackPointer == $past(stackPointer) - 1'b1)
        else $error("return did not pop the stack");
    a_ret_gie: assert property (takeRet |=> global_interrupt_enable)
        else $error("return left interrupts disabled");
    a_nop_step: assert property (takeNop |=> pc == $past(pcPlusOne)
        && $stable(accumulator) && $stable(stackPointer))
        else $error("no-op did more than step");

    c_call_then_ret: cover property (takeCall ##2 takeRet);
    c_move_zero: cover property (takeMove ##1 zeroFlag);
    c_gie_race: cover property (takeRet && gieClear);
    c_store_load: cover property (takeStore ##1 takeLoad);

endmodule

// ---- rtl/exec_pkg.sv ----
// Shared constants, opcode enumeration and instruction carrier for the executor.
// Assumes a fetch stage upstream that hands over already-decoded instructions.
// Function
// - Call pushes PC plus one on stack
// - Call loads 11-bit target, two cycles, flags kept
// - Store copies accumulator to register, one cycle
// - Immediate load fills accumulator, flags kept
// - Move sends register to accumulator or back
// - Move updates zero flag from moved value
// - Interrupt return pops stack into PC, two cycles
// - Interrupt return sets global interrupt enable
package exec_pkg;

    localparam int PC_W = 11;                // Program counter width
    localparam int ACC_W = 8;                // Accumulator and data word width
    localparam int REG_ADDR_W = 7;           // Data register address width
    localparam int STACK_DEPTH = 8;          // Return stack entries
    localparam int REG_COUNT = 128;          // Data registers addressed

    localparam logic [PC_W-1:0] PC_RESET = 11'h000;     // Reset vector
    localparam logic [PC_W-1:0] PC_STEP = 11'h001;      // Sequential advance
    localparam logic [ACC_W-1:0] ACC_RESET = 8'h00;     // Accumulator at reset
    localparam logic [ACC_W-1:0] ZERO_WORD = 8'h00;     // Zero test reference
    localparam logic DEST_ACC = 1'b0;                   // Move destination: accumulator
    localparam logic DEST_REG = 1'b1;                   // Move destination: register
    localparam logic GIE_RESET = 1'b0;                  // Interrupts off after reset

    // Decoded operation handed over by the fetch stage
    typedef enum logic [2:0] {
        OP_NOP,
        OP_LONG_SUBROUTINE_CALL,
        OP_MOVE_ACC_TO_REG,
        OP_LOAD_IMMEDIATE_ACC,
        OP_MOVE_REG_SELECT_DEST,
        OP_RETURN_ENABLE_INTERRUPTS
    } op_t;

    // One decoded instruction with all operand fields
    typedef struct packed {
        op_t op;                             // Operation
        logic [PC_W-1:0] target;             // Call target address
        logic [ACC_W-1:0] imm;               // Immediate operand
        logic [REG_ADDR_W-1:0] regAddr;      // Data register address
        logic destSel;                       // Move destination select
    } instr_t;

endpackage

// ---- verif/call_move_return_exec_tb.sv ----
// Self-checking bench for the call, move and return executor.
// Assumes the executor package is compiled first; the bench drives all ports.
`timescale 1ns/100ps

module call_move_return_exec_tb;
    logic clk = 1'b0; // 10 MHz core clock
    logic reset = 1'b1; // Held high for the first 20 cycles
    logic instrValid = 1'b0; // Offer of a decoded instruction
    logic instrReady;
    exec_pkg::instr_t instr = '0;
    logic gieClear = 1'b0; // Interrupt taken
    logic [6:0] peekAddr = 7'h00;
    logic [7:0] peekData;
    logic [10:0] pc;
    logic [7:0] accumulator;
    logic zeroFlag;
    logic global_interrupt_enable;
    logic [3:0] stackPointer;
    // Reference state, updated from the decoded instruction and the interrupt-taken level only
    logic [10:0] pcM;
    logic [7:0] accM;
    logic zM;
    logic gieM;
    logic [3:0] spM;
    logic [7:0] memM [128];
    logic [10:0] stkM [8];
    int n_mismatch = 0;
    int check_count = 0;

    call_move_return_exec i_dut (.clk(clk), .reset(reset), .instrValid(instrValid),
        .instrReady(instrReady), .instr(instr), .gieClear(gieClear), .peekAddr(peekAddr),
        .peekData(peekData), .pc(pc), .accumulator(accumulator), .zeroFlag(zeroFlag),
        .global_interrupt_enable(global_interrupt_enable), .stackPointer(stackPointer));

    // Free-running clock, 100 ns period
    initial begin
        forever #50 clk = ~clk;
    end

    // One comparison; four-state so an unknown matches only an unknown
    task automatic chk(input logic [10:0] got, input logic [10:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // Counts, verdict and end of run
    task automatic test_done;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Offer one instruction, held until taken; valid stays up so ops run back to back
    task automatic run(input exec_pkg::op_t op, input logic [10:0] tgt, input logic [7:0] imm,
                       input logic [6:0] ra, input logic d, input logic clr);
        int n;
        logic [6:0] pa;
        n = 0;
        pa = ra + 7'h01; // Peek elsewhere so read-during-write order does not matter
        instr = '{op, tgt, imm, ra, d};
        instrValid = 1'b1;
        gieClear = clr;
        peekAddr = pa;
        // Dead cycle after call or return: the offer must be ignored
        while (instrReady !== 1'b1) begin
            if (n++ == 4) begin
                n_mismatch++;
                test_done;
            end
            @(posedge clk);
            #1;
        end
        @(posedge clk);
        #1;
        // Interrupt-taken level is left as is: the next call sets it in this same step
        case (op)
            exec_pkg::OP_LONG_SUBROUTINE_CALL: begin
                stkM[spM[2:0]] = pcM + 11'h001;
                spM = spM + 4'h1;
                pcM = tgt;
            end
            exec_pkg::OP_RETURN_ENABLE_INTERRUPTS: begin
                spM = spM - 4'h1;
                pcM = stkM[spM[2:0]];
            end
            default: pcM = pcM + 11'h001;
        endcase
        // Return sets enable even against a same-cycle clear
        if (op == exec_pkg::OP_RETURN_ENABLE_INTERRUPTS) begin
            gieM = 1'b1;
        end else if (clr) begin
            gieM = 1'b0;
        end
        if (op == exec_pkg::OP_MOVE_ACC_TO_REG) memM[ra] = accM;
        if (op == exec_pkg::OP_LOAD_IMMEDIATE_ACC) accM = imm;
        if (op == exec_pkg::OP_MOVE_REG_SELECT_DEST) begin
            if (!d) accM = memM[ra];
            zM = (memM[ra] == 8'h00);
        end
        chk(pc, pcM);
        chk(stackPointer, spM);
        chk(accumulator, accM);
        chk(zeroFlag, zM);
        chk(global_interrupt_enable, gieM);
        chk(peekData, memM[pa]);
        if (op == exec_pkg::OP_LONG_SUBROUTINE_CALL ||
            op == exec_pkg::OP_RETURN_ENABLE_INTERRUPTS) chk(instrReady, 11'h000);
    endtask

    // Main sequence: reset, fill registers, corners, random mix
    initial begin
        int k;
        logic [31:0] r;
        exec_pkg::op_t op;
        r = $urandom(39753);
        repeat (20) @(posedge clk);
        #1;
        reset = 1'b0;
        pcM = 11'h000;
        accM = 8'h00;
        zM = 1'b0;
        gieM = 1'b0;
        spM = 4'h0;
        chk(pc, pcM);
        chk(stackPointer, spM);
        // Every register written once so later reads are defined
        for (k = 0; k < 128; k++) begin
            r = (k == 5) ? 32'h0 : $urandom;
            run(exec_pkg::OP_LOAD_IMMEDIATE_ACC, 11'h000, r[7:0], 7'h00, 1'b0, 1'b0);
            run(exec_pkg::OP_MOVE_ACC_TO_REG, 11'h000, 8'h00, k[6:0], 1'b0, 1'b0);
        end
        $display("test fill done");
        // Zero test in place, then move to accumulator
        run(exec_pkg::OP_LOAD_IMMEDIATE_ACC, 11'h000, 8'hff, 7'h00, 1'b0, 1'b1);
        run(exec_pkg::OP_MOVE_REG_SELECT_DEST, 11'h000, 8'h00, 7'h05, 1'b1, 1'b0);
        run(exec_pkg::OP_MOVE_REG_SELECT_DEST, 11'h000, 8'h00, 7'h05, 1'b0, 1'b0);
        // Calls to both ends of the range, two returns with a no-op between, one against a clear
        run(exec_pkg::OP_LONG_SUBROUTINE_CALL, 11'h7ff, 8'h00, 7'h00, 1'b0, 1'b0);
        run(exec_pkg::OP_LONG_SUBROUTINE_CALL, 11'h000, 8'h00, 7'h00, 1'b0, 1'b0);
        run(exec_pkg::OP_RETURN_ENABLE_INTERRUPTS, 11'h000, 8'h00, 7'h00, 1'b0, 1'b1);
        run(exec_pkg::OP_NOP, 11'h000, 8'h00, 7'h00, 1'b0, 1'b1);
        run(exec_pkg::OP_RETURN_ENABLE_INTERRUPTS, 11'h000, 8'h00, 7'h00, 1'b0, 1'b0);
        $display("test corners done");
        // Random mix; stack kept within its depth so popped entries are defined
        for (k = 0; k < 400; k++) begin
            r = $urandom;
            op = exec_pkg::op_t'(3'($urandom_range(5, 0)));
            if (op == exec_pkg::OP_RETURN_ENABLE_INTERRUPTS && spM == 4'h0) begin
                op = exec_pkg::OP_LONG_SUBROUTINE_CALL;
            end else if (op == exec_pkg::OP_LONG_SUBROUTINE_CALL && spM == 4'h7) begin
                op = exec_pkg::OP_RETURN_ENABLE_INTERRUPTS;
            end
            run(op, r[10:0], r[18:11], r[25:19], r[26], r[28:27] == 2'b00);
        end
        $display("test random done");
        instrValid = 1'b0;
        gieClear = 1'b0;
        test_done;
    end
endmodule
